// ### rtl/dpll_regs.vh
/*
 * register map, field positions and reset values of the digital PLL core.
 * assumes the includer works on a 32-bit AXI4-Lite word bus at 50 MHz.
 */
`ifndef DPLL_REGS_VH
`define DPLL_REGS_VH

// ============================================================
// register byte offsets
`define DPLL_CTRL_OFF      4'h0
`define DPLL_STAT_OFF      4'h4
`define DPLL_KCNT_OFF      4'h8
`define DPLL_ADDR_W        4

// ============================================================
// control fields
`define DPLL_CTRL_SEL_LSB  0
`define DPLL_CTRL_SEL_MSB  3
`define DPLL_CTRL_EN_BIT   4
`define DPLL_CTRL_DIR_BIT  5
`define DPLL_CTRL_RST      6'h00

// ============================================================
// status fields
`define DPLL_STAT_XOR_BIT  0
`define DPLL_STAT_EDGE_BIT 1
`define DPLL_STAT_ID_BIT   2
`define DPLL_STAT_CRY_BIT  3
`define DPLL_STAT_BRW_BIT  4

// ============================================================
// modulus counter and bus response codes
`define DPLL_KCNT_W        17
`define DPLL_KMIN_EXP      3
`define DPLL_RESP_OKAY     2'h0
`define DPLL_RESP_SLVERR   2'h2

`endif

// ### rtl/dpll_sync.v
/*
 * two-flop synchroniser, one per external level.
 * assumes inputs are asynchronous to aclk.
 */
`timescale 1ns/10ps

module dpll_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // levels
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // ============================================================
    // first flop only feeds second
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule

// ### rtl/dpll_core.v
/*
 * first-order digital PLL core: xor and edge comparators, programmable
 * up/down modulus counter with carry/borrow, increment/decrement stage.
 * assumes phase inputs and the two loop clocks come from pins and are
 * sampled on aclk; both loop clocks must run well below aclk/4.
 * control and status over AXI4-Lite.
 */
`timescale 1ns/10ps
`include "dpll_regs.vh"

// Notes on behaviour
// [R1] Select value 0 inhibits the modulus counter, value s gives modulus 2^(s+2), up to 2^17.
// [R2] Two independent comparators, xor and edge-controlled, each drive their own output.
// [R3] Edge output sets on a falling shared phase edge, clears on a falling own phase edge, ignores rises.
// [R4] The modulus counter steps up or down on each rising edge of its clock per the direction input.
// [R5] Wrapping while counting up emits a one-cycle carry toward the inc/dec stage.
// [R6] Wrapping while counting down emits a one-cycle borrow toward the inc/dec stage.
// [R7] Without carry or borrow the inc/dec output toggles at half its clock rate.
// [R8] A carry inserts one extra output pulse, a borrow removes one output pulse.
// [R9] Counting happens only while the count enable is asserted at the counter clock edge.
module dpll_core (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // loop pins
    input  wire        xor_phase_in,
    input  wire        edge_phase_in,
    input  wire        shared_phase_in,
    input  wire        kclk_in,
    input  wire        idclk_in,
    output reg         xor_comparator_out,
    output reg         edge_comparator_out,
    output reg         id_out,
    // axi write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi read
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    localparam KW = `DPLL_KCNT_W;

    // ============================================================
    // pin synchronisers
    wire [4:0] pin_s;
    dpll_sync #(.W(5)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({idclk_in, kclk_in, shared_phase_in, edge_phase_in, xor_phase_in}),
        .q       (pin_s)
    );
    wire xa_s = pin_s[0];
    wire ea_s = pin_s[1];
    wire sb_s = pin_s[2];
    wire kc_s = pin_s[3];
    wire ic_s = pin_s[4];

    reg  [2:0] prev_r;
    wire       ea_fall = prev_r[0] & ~ea_s;
    wire       sb_fall = prev_r[1] & ~sb_s;
    wire       kc_rise = ~prev_r[2] & kc_s;
    reg        ic_prev_r;
    wire       ic_rise = ~ic_prev_r & ic_s;
    wire       ic_fall = ic_prev_r & ~ic_s;

    // ============================================================
    // control register
    reg  [5:0] ctrl_r;
    wire [3:0] sel   = ctrl_r[`DPLL_CTRL_SEL_MSB:`DPLL_CTRL_SEL_LSB];
    wire       en    = ctrl_r[`DPLL_CTRL_EN_BIT];
    wire       dn_sw = ctrl_r[`DPLL_CTRL_DIR_BIT];
    // direction: software bit 1 means down; 0 follows the xor comparator (high = down)
    wire       down  = dn_sw | xor_comparator_out;

    // ============================================================
    // comparators
    always @(posedge aclk) begin
        if (!aresetn) begin
            xor_comparator_out  <= 1'b0;
            edge_comparator_out <= 1'b0;
            prev_r              <= 3'h0;
            ic_prev_r           <= 1'b0;
        end else begin
            prev_r <= {kc_s, sb_s, ea_s};
            ic_prev_r <= ic_s;
            xor_comparator_out <= xa_s ^ sb_s; // see [R2]
            if (sb_fall)
                edge_comparator_out <= 1'b1; // see [R3]
            else if (ea_fall)
                edge_comparator_out <= 1'b0; // see [R3]
        end
    end

    // ============================================================
    // modulus counter
    reg  [KW-1:0] kcnt_r;
    reg  [KW-1:0] kmax;
    reg           carry_r;
    reg           borrow_r;
    always @* begin
        kmax = {KW{1'b0}};
        if (sel != 4'h0)
            // 5-bit shift count: a 4-bit sum wraps to zero for select 14
            kmax = ({{(KW-1){1'b0}}, 1'b1} << ({1'b0, sel} + 5'h02)) - {{(KW-1){1'b0}}, 1'b1}; // see [R1]
        if (sel == 4'hF)
            kmax = {KW{1'b1}};
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            kcnt_r   <= {KW{1'b0}};
            carry_r  <= 1'b0;
            borrow_r <= 1'b0;
        end else begin
            carry_r  <= 1'b0;
            borrow_r <= 1'b0;
            if (sel == 4'h0) begin
                kcnt_r <= {KW{1'b0}}; // see [R1]
            end else if (kc_rise && en) begin // see [R9]
                if (!down) begin // see [R4]
                    if (kcnt_r >= kmax) begin
                        kcnt_r  <= {KW{1'b0}};
                        carry_r <= 1'b1; // see [R5]
                    end else begin
                        kcnt_r <= kcnt_r + {{(KW-1){1'b0}}, 1'b1};
                    end
                end else begin
                    if (kcnt_r == {KW{1'b0}} || kcnt_r > kmax) begin
                        kcnt_r   <= kmax;
                        borrow_r <= 1'b1; // see [R6]
                    end else begin
                        kcnt_r <= kcnt_r - {{(KW-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end

    // ============================================================
    // increment/decrement stage
    // pending flags held until served; set wins the clear
    // inserted pulse is one aclk wide inside a low half, so the toggle phase is kept
    // limitation: needs the id clock low for two aclk cycles at least
    reg  ins_r;
    reg  del_r;
    reg  ext_r;
    reg  skip_r;
    wire ins_go = ic_fall && ins_r && !id_out && !ext_r;
    wire del_go = ic_rise && del_r && !ins_r && !id_out && !skip_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            id_out <= 1'b0;
            ins_r  <= 1'b0;
            del_r  <= 1'b0;
            ext_r  <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            ext_r <= ins_go;
            if (ext_r)
                id_out <= 1'b0; // see [R8]
            else if (ins_go)
                id_out <= 1'b1; // see [R8]
            else if (ic_rise && !del_go && !skip_r)
                id_out <= ~id_out; // see [R7]
            // a deleted pulse swallows two toggles: its rise and its fall
            if (ic_rise)
                skip_r <= del_go; // see [R8]
            if (carry_r)
                ins_r <= 1'b1;
            else if (ins_go)
                ins_r <= 1'b0;
            if (borrow_r)
                del_r <= 1'b1;
            else if (del_go)
                del_r <= 1'b0;
        end
    end

    // ============================================================
    // axi4-lite slave
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [3:0]  awa_r;
    reg [31:0] wd_r;
    reg [3:0]  ws_r;
    wire       do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
    wire [3:0] ara   = s_axi_araddr[3:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DPLL_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `DPLL_RESP_OKAY;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awa_r         <= 4'h0;
            wd_r          <= 32'h0;
            ws_r          <= 4'h0;
            ctrl_r        <= `DPLL_CTRL_RST;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awa_r     <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wd_r     <= s_axi_wdata;
                ws_r     <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `DPLL_RESP_OKAY;
                if (awa_r == `DPLL_CTRL_OFF) begin
                    if (ws_r[0])
                        ctrl_r <= wd_r[5:0];
                end else if (awa_r != `DPLL_STAT_OFF && awa_r != `DPLL_KCNT_OFF) begin
                    s_axi_bresp <= `DPLL_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `DPLL_RESP_OKAY;
                s_axi_rdata  <= 32'h0;
                case (ara)
                    `DPLL_CTRL_OFF: s_axi_rdata <= {26'h0, ctrl_r};
                    `DPLL_STAT_OFF: s_axi_rdata <= {27'h0, del_r, ins_r, id_out,
                                                    edge_comparator_out, xor_comparator_out};
                    `DPLL_KCNT_OFF: s_axi_rdata <= {15'h0, kcnt_r};
                    default:        s_axi_rresp <= `DPLL_RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ### tb/fodpc_sva.sv
/*
 * pin and handshake checks for dpll_core.
 * assumes one aclk domain with synchronous active-low aresetn.
 */
`timescale 1ns/10ps

module fodpc_sva (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // loop pins
    input wire xor_phase_in,
    input wire edge_phase_in,
    input wire shared_phase_in,
    input wire idclk_in,
    input wire xor_comparator_out,
    input wire edge_comparator_out,
    input wire id_out,
    // bus handshakes
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire s_axi_bready
);
    logic [3:0] warm_r, sh_age_r, own_age_r, id_age_r;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ages saturate so a quiet spell never wraps into a false cause
    always @(posedge aclk) begin
        if (!aresetn) begin
            warm_r    <= 4'h0;
            sh_age_r  <= 4'hF;
            own_age_r <= 4'hF;
            id_age_r  <= 4'hF;
        end else begin
            warm_r    <= warm_r + {3'h0, warm_r != 4'hF};
            sh_age_r  <= $fell(shared_phase_in) ? 4'h0 : sh_age_r + {3'h0, sh_age_r != 4'hF};
            own_age_r <= $fell(edge_phase_in) ? 4'h0 : own_age_r + {3'h0, own_age_r != 4'hF};
            id_age_r  <= $rose(idclk_in) ? 4'h0 : id_age_r + {3'h0, id_age_r != 4'hF};
        end
    end

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_answer;
        ##[1:2] s_axi_rvalid;
    endsequence

    a_xor_follows: assert property (warm_r == 4'hF |->
        xor_comparator_out == $past(xor_phase_in ^ shared_phase_in, 3)) else $error("xor output wrong");
    a_edge_sets: assert property (warm_r > 4'h8 && $fell(shared_phase_in) |->
        ##[1:6] edge_comparator_out) else $error("edge output not set");
    a_edge_clears: assert property (warm_r > 4'h8 && $fell(edge_phase_in) && sh_age_r > 4'h8
        && !$fell(shared_phase_in) |-> ##[1:6] !edge_comparator_out) else $error("edge output not cleared");
    a_edge_rise_cause: assert property ($rose(edge_comparator_out) |-> sh_age_r < 4'h7)
        else $error("edge output rose alone");
    a_edge_fall_cause: assert property ($fell(edge_comparator_out) |-> own_age_r < 4'h7)
        else $error("edge output fell alone");
    a_id_cause: assert property ($changed(id_out) |-> id_age_r < 4'h9)
        else $error("inc dec output moved alone");
    a_reset_quiet: assert property ($rose(aresetn) |-> !xor_comparator_out && !edge_comparator_out
        && !id_out && !s_axi_rvalid && !s_axi_bvalid) else $error("outputs not idle after reset");
    a_read_answer: assert property (s_rd_taken |-> s_rd_answer) else $error("read not answered");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write repeated");
endmodule

bind dpll_core fodpc_sva chk_u (.aclk, .aresetn, .xor_phase_in, .edge_phase_in, .shared_phase_in, .idclk_in,
    .xor_comparator_out, .edge_comparator_out, .id_out, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready);

// ### tb/fodpc_divn.sv
/*
 * divide-by-n counter closing the loop onto the shared phase input.
 * assumes clk_in is a level registered on aclk.
 */
`timescale 1ns/10ps

module fodpc_divn #(
    parameter N = 4
) (
    // clock and reset
    input  wire  aclk,
    input  wire  aresetn,
    // loop
    input  wire  clk_in,
    output logic q
);
    logic       in_r;
    logic [7:0] cnt_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            in_r  <= 1'h0;
            cnt_r <= 8'h0;
            q     <= 1'h0;
        end else begin
            in_r <= clk_in;
            if (clk_in && !in_r)
                cnt_r <= (cnt_r == N - 1) ? 8'h0 : cnt_r + 8'h1;
            q <= (cnt_r < N / 2);
        end
    end
endmodule

// ### tb/tb_top.sv
/*
 * bench for dpll_core: row table, bus errors, reset, inc/dec counts.
 * assumes the divider model and the bound checker.
 */
`timescale 1ns/10ps
`include "dpll_regs.vh"

module tb_top;
    typedef struct packed {
        logic [2:0]  pins;
        logic [7:0]  ctrl;
        logic [7:0]  n;
        logic [16:0] kc;
        logic [1:0]  outs;
    } fodpc_row_t;

    fodpc_row_t  rows [11];
    logic        aclk, aresetn, xor_phase_in, edge_phase_in, sh_r, kclk_in, idclk_in, loop_on, id_q, div_q;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        xor_comparator_out, edge_comparator_out, id_out;
    wire         shared_phase_in = loop_on ? div_q : sh_r;
    int          n_fail = 0, tests_run = 0, n_id = 0, base;

    dpll_core dut_u (.aclk, .aresetn, .xor_phase_in, .edge_phase_in, .shared_phase_in, .kclk_in, .idclk_in,
        .xor_comparator_out, .edge_comparator_out, .id_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fodpc_divn #(.N(4)) div_u (.aclk, .aresetn, .clk_in(id_out), .q(div_q));

    always #10 aclk = ~aclk;

    always @(posedge aclk) begin
        id_q <= id_out;
        if (id_out === 1'h1 && id_q === 1'h0)
            n_id <= n_id + 1;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // d is write data, or the expected read data
    task automatic acc(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        if (w) begin
            s_axi_awaddr  <= {28'h0, a};
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid  <= 1'h1;
            s_axi_bready  <= 1'h1;
        end else begin
            s_axi_araddr  <= {28'h0, a};
            s_axi_arvalid <= 1'h1;
            s_axi_rready  <= 1'h1;
        end
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
            if ((s_axi_bvalid & s_axi_bready) === 1'h1 || (s_axi_rvalid & s_axi_rready) === 1'h1)
                break;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        if (i == 40) begin
            n_fail++;
            $display("BAD %0t bus timeout", $time);
            print_verdict();
        end else begin
            chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
            if (!w)
                chk(s_axi_rdata, d);
            // idle edge: the next call must not re-drive a ready in this step
            @(posedge aclk);
        end
    endtask

    // loop clocks kept well under aclk/4
    task automatic pulses(input bit k, input logic [7:0] n);
        repeat (n) begin
            if (k)
                kclk_in <= 1'h1;
            else
                idclk_in <= 1'h1;
            repeat (4) @(posedge aclk);
            kclk_in  <= 1'h0;
            idclk_in <= 1'h0;
            repeat (4) @(posedge aclk);
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask

    task automatic id_count(input int exp);
        base = n_id;
        pulses(1'h0, 8'h08);
        chk(n_id - base, exp);
    endtask

    initial begin
        {aclk, aresetn, xor_phase_in, edge_phase_in, sh_r, kclk_in, idclk_in, loop_on} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        rows = '{'{3'h0, 8'h11, 8'h07, 17'h07, 2'h0}, '{3'h1, 8'h11, 8'h00, 17'h07, 2'h2},
                 '{3'h0, 8'h11, 8'h01, 17'h00, 2'h1}, '{3'h2, 8'h10, 8'h05, 17'h00, 2'h1},
                 '{3'h0, 8'h02, 8'h03, 17'h00, 2'h0}, '{3'h4, 8'h12, 8'h01, 17'h0F, 2'h2},
                 '{3'h5, 8'h12, 8'h02, 17'h01, 2'h0}, '{3'h6, 8'h13, 8'h02, 17'h1F, 2'h3},
                 '{3'h0, 8'h33, 8'h01, 17'h1E, 2'h0}, '{3'h3, 8'h33, 8'h00, 17'h1E, 2'h2},
                 '{3'h0, 8'h33, 8'h00, 17'h1E, 2'h1}};
        do_reset();
        foreach (rows[k]) begin
            {xor_phase_in, edge_phase_in, sh_r} <= rows[k].pins;
            repeat (8) @(posedge aclk);
            acc(1'h1, `DPLL_CTRL_OFF, {24'h0, rows[k].ctrl}, `DPLL_RESP_OKAY);
            pulses(1'h1, rows[k].n);
            chk({30'h0, xor_comparator_out, edge_comparator_out}, {30'h0, rows[k].outs});
            acc(1'h0, `DPLL_KCNT_OFF, {15'h0, rows[k].kc}, `DPLL_RESP_OKAY);
            $display("row %0d done", k);
        end
        acc(1'h1, 4'hC, 32'h1, `DPLL_RESP_SLVERR);
        acc(1'h0, 4'hC, 32'h0, `DPLL_RESP_SLVERR);
        acc(1'h1, `DPLL_KCNT_OFF, 32'h5, `DPLL_RESP_OKAY);
        acc(1'h0, `DPLL_KCNT_OFF, 32'h1E, `DPLL_RESP_OKAY);
        $display("bus refusals done");
        do_reset();
        acc(1'h0, `DPLL_CTRL_OFF, {26'h0, `DPLL_CTRL_RST}, `DPLL_RESP_OKAY);
        acc(1'h0, `DPLL_KCNT_OFF, 32'h0, `DPLL_RESP_OKAY);
        id_count(4);
        $display("reset and half rate done");
        acc(1'h1, `DPLL_CTRL_OFF, 32'h11, `DPLL_RESP_OKAY);
        pulses(1'h1, 8'h08);
        acc(1'h0, `DPLL_STAT_OFF, 32'h8, `DPLL_RESP_OKAY);
        id_count(5);
        acc(1'h1, `DPLL_CTRL_OFF, 32'h31, `DPLL_RESP_OKAY);
        pulses(1'h1, 8'h01);
        acc(1'h0, `DPLL_STAT_OFF, 32'h10, `DPLL_RESP_OKAY);
        id_count(3);
        $display("insert and delete done");
        loop_on <= 1'h1;
        pulses(1'h0, 8'h10);
        repeat (8) @(posedge aclk);
        chk({31'h0, xor_comparator_out}, {31'h0, div_q});
        $display("closed loop done");
        print_verdict();
    end
endmodule
